// ### acsr_regs.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Offset trim is nine bits: register 3 bit 0 above register 4.
// - Each trim code step moves converter offset by one quarter-code step.
// - Trim comes up with the per-device factory value, not a constant.
// - Control bit 5 resets to one; host writes it as one.
// - Control bit 1 staggers bus B against bus A when set.
// - Control bit 2 picks external reference when set, internal default.
// - Control bit 3 picks two's complement, else offset binary.
// - Control bit 6 puts converter to sleep; reset value is active.
// - Control bit 7 enables temperature sensor, even while asleep.
// - Driver bits 1:0: 10 forces outputs low, 11 forces high.
// - Driver bits 3:2 set drive current; reset code 01.
// - Driver bits 5:4: 10 gives 200 ohm, 11 gives 100 ohm.
// - Driver bits 7:6 set output data mode; 00 is normal.
// - Register 8 reads die temperature when enabled; writes ignored.
// - Register 9 is read-only, resets zero, upper seven bits zero.
// - Register 9 bit 0 flags disagreement among redundant stored copies.
// - Trim MSB lives in bit 0 of register 3.
module acsr_regs (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic [acsr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [acsr_pkg::DATA_W-1:0] reg_wdata,
  output logic [acsr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [acsr_pkg::TRIM_W-1:0] factory_trim,
  input wire logic [acsr_pkg::DATA_W-1:0] temp_code,
  output logic [acsr_pkg::TRIM_W-1:0] offset_trim,
  output logic trim_ready,
  output logic bus_stagger,
  output logic ext_ref_sel,
  output logic twos_comp,
  output logic sync_mode,
  output logic sleep_mode,
  output logic temp_sensor_en,
  output logic force_low,
  output logic force_high,
  output logic [1:0] drive_current,
  output logic term_200,
  output logic term_100,
  output logic [1:0] data_out_mode,
  output logic mem_error
);
  import acsr_pkg::*;

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  logic [TRIM_W-1:0] trim_meta;
  logic [TRIM_W-1:0] trim_sync;
  logic [DATA_W-1:0] temp_meta;
  logic [DATA_W-1:0] temp_sync;

  always_ff @(posedge core_clk) begin
    trim_meta <= factory_trim;
    trim_sync <= trim_meta;
    temp_meta <= temp_code;
    temp_sync <= temp_meta;
  end

  // ***************************************************
  // Temperature capture
  // ***************************************************
  logic [DATA_W-1:0] temp_prev;
  logic [DATA_W-1:0] temp_hold;

  // Bits of the async byte may settle on different edges;
  // only a value seen on two edges in a row is taken
  always_ff @(posedge core_clk) begin
    temp_prev <= temp_sync;
    if (temp_sync == temp_prev) begin
      temp_hold <= temp_sync;
    end
  end

  // ***************************************************
  // Factory trim load after reset
  // ***************************************************
  logic [1:0] load_cnt;

  // Two cycles let the strap pass both synchroniser stages
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_cnt <= 2'h0;
      trim_ready <= 1'b0;
    end else if (!trim_ready) begin
      load_cnt <= load_cnt + 2'h1;
      trim_ready <= (load_cnt == 2'h2);
    end
  end

  logic trim_load;
  assign trim_load = !trim_ready && (load_cnt == 2'h2);

  // ***************************************************
  // Redundant configuration storage
  // ***************************************************
  logic [DATA_W-1:0] cfg [CFG_COPIES][CFG_WORDS];
  logic wr_trim_hi;
  logic wr_trim_lo;
  logic wr_conv;
  logic wr_drv;

  assign wr_trim_hi = reg_wr && (reg_addr == ADDR_TRIM_HIGH);
  assign wr_trim_lo = reg_wr && (reg_addr == ADDR_TRIM_LOW);
  assign wr_conv = reg_wr && (reg_addr == ADDR_CONV_CTRL);
  assign wr_drv = reg_wr && (reg_addr == ADDR_DRV_CTRL);

  // One process writes every copy, so storage has a single driver
  always_ff @(posedge core_clk) begin
    for (int c = 0; c < CFG_COPIES; c++) begin
      if (srst) begin
        cfg[c][IDX_TRIM_HIGH] <= 8'h00;
        cfg[c][IDX_TRIM_LOW] <= 8'h00;
        cfg[c][IDX_CONV] <= CONV_CTRL_RST;
        cfg[c][IDX_DRV] <= DRV_CTRL_RST;
      end else begin
        if (trim_load) begin
          cfg[c][IDX_TRIM_HIGH] <= {7'h00, trim_sync[8]};
          cfg[c][IDX_TRIM_LOW] <= trim_sync[7:0];
        end else begin
          if (wr_trim_hi) begin
            cfg[c][IDX_TRIM_HIGH] <= reg_wdata & TRIM_HIGH_MASK;
          end
          if (wr_trim_lo) begin
            cfg[c][IDX_TRIM_LOW] <= reg_wdata;
          end
        end
        if (wr_conv) begin
          // Reserved bit 0 is not stored; host keeps it zero
          cfg[c][IDX_CONV] <= reg_wdata & CONV_CTRL_MASK;
        end
        if (wr_drv) begin
          cfg[c][IDX_DRV] <= reg_wdata;
        end
      end
    end
  end

  // ***************************************************
  // Copy comparison
  // ***************************************************
  logic next_mem_error;

  always_comb begin
    next_mem_error = 1'b0;
    for (int w = 0; w < CFG_WORDS; w++) begin
      if (cfg[0][w] != cfg[1][w] || cfg[0][w] != cfg[2][w]) begin
        next_mem_error = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_error <= 1'b0;
    end else begin
      mem_error <= next_mem_error;
    end
  end

  // ***************************************************
  // Control outputs
  // ***************************************************
  logic [DATA_W-1:0] conv;
  logic [DATA_W-1:0] drv;

  assign conv = cfg[0][IDX_CONV];
  assign drv = cfg[0][IDX_DRV];
  // Each code step is one quarter-code offset step in the analog trim
  assign offset_trim = {cfg[0][IDX_TRIM_HIGH][0],
                        cfg[0][IDX_TRIM_LOW]};
  assign bus_stagger = conv[CC_STAGGER];
  assign ext_ref_sel = conv[CC_EXT_REF];
  assign twos_comp = conv[CC_TWOS];
  assign sync_mode = conv[CC_SYNC];
  assign sleep_mode = conv[CC_SLEEP];
  assign temp_sensor_en = conv[CC_TEMP_EN];
  assign force_low = (drv[DC_FORCE_LO+:2] == FORCE_LOW_CODE);
  assign force_high = (drv[DC_FORCE_LO+:2] == FORCE_HIGH_CODE);
  assign drive_current = drv[DC_CUR_LO+:2];
  assign term_200 = (drv[DC_TERM_LO+:2] == TERM_200_CODE);
  assign term_100 = (drv[DC_TERM_LO+:2] == TERM_100_CODE);
  assign data_out_mode = drv[DC_MODE_LO+:2];

  // ***************************************************
  // Read path
  // ***************************************************
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    unique case (reg_addr)
      ADDR_TRIM_HIGH: next_rdata = cfg[0][IDX_TRIM_HIGH];
      ADDR_TRIM_LOW: next_rdata = cfg[0][IDX_TRIM_LOW];
      ADDR_CONV_CTRL: next_rdata = conv;
      ADDR_DRV_CTRL: next_rdata = drv;
      // Sensor value is meaningless unless the sensor is on
      ADDR_DIE_TEMP: next_rdata = temp_sensor_en ? temp_hold
                                                 : TEMP_OFF_VALUE;
      ADDR_INTEG_STAT: next_rdata = {7'h00, mem_error};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_conv_write;
    reg_wr && reg_addr == ADDR_CONV_CTRL;
  endsequence

  sequence s_drv_write;
    reg_wr && reg_addr == ADDR_DRV_CTRL;
  endsequence

  sequence s_trim_lo_write;
    reg_wr && reg_addr == ADDR_TRIM_LOW;
  endsequence

  chk_trim_compose: assert property (
    s_trim_lo_write ##0 trim_ready |=> offset_trim[7:0] == $past(reg_wdata)
      && offset_trim[8] == $past(offset_trim[8]))
    else $error("offset trim not formed from both trim registers");

  chk_trim_factory: assert property (
    $rose(trim_ready) |-> offset_trim == $past(trim_sync))
    else $error("trim not loaded with factory value");

  chk_ctrl_apply: assert property (
    s_conv_write ##0 trim_ready |=>
      conv == ($past(reg_wdata) & CONV_CTRL_MASK))
    else $error("control write not applied next cycle");

  chk_stagger_sleep: assert property (
    s_conv_write |=> bus_stagger == $past(reg_wdata[CC_STAGGER])
      && sleep_mode == $past(reg_wdata[CC_SLEEP]))
    else $error("stagger or sleep not following write");

  chk_force_out: assert property (
    s_drv_write |=> force_high == ($past(reg_wdata[1:0]) == 2'h3)
      && force_low == ($past(reg_wdata[1:0]) == 2'h2))
    else $error("force levels wrong after driver write");

  chk_term_sel: assert property (
    s_drv_write |=> term_200 == ($past(reg_wdata[DC_TERM_LO+:2]) == 2'h2)
      && term_100 == ($past(reg_wdata[DC_TERM_LO+:2]) == 2'h3)
      && !(term_200 && term_100))
    else $error("termination select decode wrong");

  chk_temp_read: assert property (
    reg_addr == ADDR_DIE_TEMP && !temp_sensor_en |=> reg_rdata == 8'h00)
    else $error("temperature read while sensor off not zero");

  chk_status_read: assert property (
    reg_addr == ADDR_INTEG_STAT ##1 1'b1 |->
      reg_rdata[7:1] == 7'h00 && reg_rdata[0] == $past(mem_error))
    else $error("status register read wrong");

  chk_mem_error: assert property (
    (cfg[0][IDX_CONV] != cfg[1][IDX_CONV]) |=> mem_error)
    else $error("copy disagreement not flagged");

  chk_rsvd_one: assert property (
    $fell(srst) |-> conv == CONV_CTRL_RST && drv == DRV_CTRL_RST
      && !mem_error)
    else $error("control reset value wrong");

  chk_trim_ready: assert property (
    $fell(srst) |-> !trim_ready ##3 trim_ready)
    else $error("factory trim not loaded on third edge");

  chk_temp_live: assert property (
    reg_addr == ADDR_DIE_TEMP && temp_sensor_en |=> reg_rdata == $past(temp_hold))
    else $error("temperature read while sensor on wrong");

  chk_cur_apply: assert property (
    s_drv_write |=> drive_current == $past(reg_wdata[DC_CUR_LO+:2])
      && data_out_mode == $past(reg_wdata[DC_MODE_LO+:2]))
    else $error("drive current or output mode not following write");

  chk_ref_format: assert property (
    s_conv_write |=> ext_ref_sel == $past(reg_wdata[CC_EXT_REF])
      && twos_comp == $past(reg_wdata[CC_TWOS])
      && temp_sensor_en == $past(reg_wdata[CC_TEMP_EN]))
    else $error("reference, format or sensor enable not following write");

endmodule
`default_nettype wire

// ### acsr_pkg.sv
package acsr_pkg;
  // ***************************************************
  // Register map
  // ***************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] ADDR_TRIM_HIGH = 5'h03;
  localparam logic [4:0] ADDR_TRIM_LOW = 5'h04;
  localparam logic [4:0] ADDR_CONV_CTRL = 5'h05;
  localparam logic [4:0] ADDR_DRV_CTRL = 5'h06;
  localparam logic [4:0] ADDR_DIE_TEMP = 5'h08;
  localparam logic [4:0] ADDR_INTEG_STAT = 5'h09;
  // Stored configuration words and redundant copies
  localparam int CFG_WORDS = 4;
  localparam int CFG_COPIES = 3;
  localparam int IDX_TRIM_HIGH = 0;
  localparam int IDX_TRIM_LOW = 1;
  localparam int IDX_CONV = 2;
  localparam int IDX_DRV = 3;
  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int TRIM_W = 9;
  localparam int CC_RSVD0 = 0;
  localparam int CC_STAGGER = 1;
  localparam int CC_EXT_REF = 2;
  localparam int CC_TWOS = 3;
  localparam int CC_SYNC = 4;
  localparam int CC_RSVD1 = 5;
  localparam int CC_SLEEP = 6;
  localparam int CC_TEMP_EN = 7;
  localparam int DC_FORCE_LO = 0;
  localparam int DC_CUR_LO = 2;
  localparam int DC_TERM_LO = 4;
  localparam int DC_MODE_LO = 6;
  // ***************************************************
  // Reset values and codes
  // ***************************************************
  localparam logic [7:0] CONV_CTRL_RST = 8'h20;
  localparam logic [7:0] DRV_CTRL_RST = 8'h04;
  localparam logic [7:0] TRIM_HIGH_MASK = 8'h01;
  localparam logic [7:0] CONV_CTRL_MASK = 8'hFE;
  localparam logic [1:0] FORCE_LOW_CODE = 2'h2;
  localparam logic [1:0] FORCE_HIGH_CODE = 2'h3;
  localparam logic [1:0] TERM_200_CODE = 2'h2;
  localparam logic [1:0] TERM_100_CODE = 2'h3;
  localparam logic [7:0] TEMP_OFF_VALUE = 8'h00;
endpackage

// ### acsr_host.sv
`timescale 1ns/100ps
`default_nettype none
module acsr_host (
  input wire logic core_clk,
  output var logic reg_wr,
  output var logic [acsr_pkg::ADDR_W-1:0] reg_addr,
  output var logic [acsr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [acsr_pkg::DATA_W-1:0] reg_rdata
);
  import acsr_pkg::*;
  // ****************************
  // Host bus tasks
  // ****************************
  initial begin
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic wr_ctrl(input logic [7:0] d);
    wr(ADDR_CONV_CTRL, (d & 8'hFE) | 8'h20);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask
  function automatic int celsius(input logic [7:0] t);
    return int'(t) - 78;
  endfunction
endmodule
`default_nettype wire

// ### acsr_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module acsr_regs_tb;
  import acsr_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [TRIM_W-1:0] factory_trim = 9'h15A;
  logic [7:0] temp_code = 8'h73;
  logic [TRIM_W-1:0] offset_trim;
  logic trim_ready, bus_stagger, ext_ref_sel, twos_comp, sync_mode;
  logic sleep_mode, temp_sensor_en, force_low, force_high, term_200;
  logic term_100, mem_error;
  logic [1:0] drive_current, data_out_mode;
  logic [7:0] e;
  int mismatches = 0;
  int tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  acsr_regs acsr_regs_i (.core_clk, .srst, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .factory_trim, .temp_code, .offset_trim, .trim_ready,
    .bus_stagger, .ext_ref_sel, .twos_comp, .sync_mode, .sleep_mode,
    .temp_sensor_en, .force_low, .force_high, .drive_current, .term_200,
    .term_100, .data_out_mode, .mem_error);
  acsr_host acsr_host_i (.core_clk, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] x);
    logic [7:0] v;
    acsr_host_i.rd(a, v);
    check({8'h00, v}, {8'h00, x});
  endtask
  task automatic wait_trim;
    for (int i = 0; i < 20 && trim_ready !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic results;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    results;
  end
  // ****************************
  // Stimulus and checks
  // ****************************
  initial begin
    repeat (3) @(posedge core_clk);
    #1 srst = 1'b0;
    check({sleep_mode, ext_ref_sel, drive_current}, 4'h1);
    check({trim_ready, mem_error}, 2'h0);
    rdchk(ADDR_CONV_CTRL, 8'h20);
    rdchk(ADDR_DRV_CTRL, 8'h04);
    rdchk(ADDR_INTEG_STAT, 8'h00);
    wait_trim;
    check(trim_ready, 1'b1);
    check(offset_trim, factory_trim);
    rdchk(ADDR_TRIM_HIGH, {7'h00, factory_trim[8]});
    rdchk(ADDR_TRIM_LOW, factory_trim[7:0]);
    acsr_host_i.wr(ADDR_TRIM_HIGH, 8'hFF);
    acsr_host_i.wr(ADDR_TRIM_LOW, 8'hFF);
    check(offset_trim, 9'h1FF);
    rdchk(ADDR_TRIM_HIGH, 8'h01);
    acsr_host_i.wr(ADDR_TRIM_HIGH, 8'h00);
    acsr_host_i.wr(ADDR_TRIM_LOW, 8'h01);
    check(offset_trim, 9'h001);
    for (int b = 0; b < 8; b++) begin
      e = ((8'h01 << b) & 8'hFE) | 8'h20;
      acsr_host_i.wr_ctrl(8'h01 << b);
      check({temp_sensor_en, sleep_mode, sync_mode, twos_comp, ext_ref_sel,
        bus_stagger}, {e[7:6], e[4:1]});
      rdchk(ADDR_CONV_CTRL, e);
    end
    acsr_host_i.wr_ctrl(8'hFF);
    rdchk(ADDR_CONV_CTRL, 8'hFE);
    for (int v = 0; v < 256; v++) begin
      e = v[7:0];
      acsr_host_i.wr(ADDR_DRV_CTRL, e);
      check({force_low, force_high, drive_current, term_200, term_100,
        data_out_mode}, {e[1:0] == 2'h2, e[1:0] == 2'h3, e[3:2],
        e[5:4] == 2'h2, e[5:4] == 2'h3, e[7:6]});
    end
    rdchk(ADDR_DRV_CTRL, 8'hFF);
    acsr_host_i.wr_ctrl(8'h40);
    rdchk(ADDR_DIE_TEMP, 8'h00);
    acsr_host_i.wr_ctrl(8'hC0);
    rdchk(ADDR_DIE_TEMP, 8'h73);
    acsr_host_i.wr(ADDR_DIE_TEMP, 8'h55);
    rdchk(ADDR_DIE_TEMP, 8'h73);
    temp_code = 8'hAF;
    repeat (3) @(posedge core_clk);
    rdchk(ADDR_DIE_TEMP, 8'hAF);
    check(16'(acsr_host_i.celsius(8'hAF)), 16'h0061);
    acsr_host_i.wr(ADDR_INTEG_STAT, 8'hFF);
    rdchk(ADDR_INTEG_STAT, 8'h00);
    rdchk(5'h1F, 8'h00);
    @(posedge core_clk);
    #1 srst = 1'b1;
    @(posedge core_clk);
    #1 srst = 1'b0;
    rdchk(ADDR_CONV_CTRL, 8'h20);
    rdchk(ADDR_DRV_CTRL, 8'h04);
    wait_trim;
    check(trim_ready, 1'b1);
    check(offset_trim, factory_trim);
    results;
  end
endmodule
`default_nettype wire
